//--- src/urpu_top.sv
// serial receiver with two-entry buffer, tx parity insertion, axi4-lite registers
`timescale 1ns/1ns
module urpu_top
  import urpu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        serial_in_pin,
  input  wire logic        transfer_clock_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             rx_pin_owned,
  output logic             rx_irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic              rs1, rs2, xs1, xs2, xs3; // pin synchronisers
    logic [7:0]        ctrl, cfg;      // control and frame config
    logic              u2x;            // double speed
    logic [15:0]       baud, bcnt;     // oversample divisor, counter
    urpu_rx_st_t       st;             // receive state
    logic [4:0]        scnt;           // sample number within bit
    logic [1:0]        v;              // first two centre samples
    logic              rprev;          // line at previous tick
    logic [3:0]        bidx;           // received bit index
    logic [9:0]        sh;             // receive shift register
    urpu_ent_t [1:0]   fifo;           // receive buffer
    logic              rp, wp;         // buffer pointers
    logic [1:0]        cnt;            // buffer fill
    urpu_ent_t         pend;           // complete char in shifter
    logic              pend_v, ovr;    // waiting char, overrun seen
    logic [8:0]        tbuf;           // transmit buffer
    logic              tbuf_v, tbusy;  // tx buffer full, shifting
    logic [12:0]       frm;            // outgoing frame, lsb first
    logic [3:0]        tleft;          // bits left in frame
    logic [4:0]        tcnt;           // tx samples within bit
    logic              out, toe, own, irq;
    logic              awr, wr, bv, arr, rv;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
  } urpu_state_t;

  urpu_state_t q, d;
  logic        tick, xck_rise, sync, dec, bitv, tx_bt;  // shared strobes
  logic        start_ok, done, push, pop;
  urpu_ent_t   push_ent, fr, head;
  logic [4:0]  spb, mid;
  logic [3:0]  sz, nbits;
  logic [8:0]  mask, tm;
  logic [12:0] tfrm;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    d = q;
    push = 1'b0;
    pop = 1'b0;
    start_ok = 1'b0;
    done = 1'b0;
    push_ent = '0;
    tfrm = 13'h1fff;
    // two flip-flops before any pin is looked at
    d.rs1 = serial_in_pin;
    d.rs2 = q.rs1;
    d.xs1 = transfer_clock_pin;
    d.xs2 = q.xs1;
    d.xs3 = q.xs2;
    xck_rise = q.xs2 & ~q.xs3;
    sync = q.cfg[URPU_CFG_SYNC];
    // oversample tick from the divisor
    tick = (q.bcnt == 16'h0000);
    d.bcnt = tick ? q.baud : q.bcnt - 16'h0001;
    spb = q.u2x ? URPU_OSR_DBL : URPU_OSR_NORM;
    mid = spb >> 1;
    // character size 5..9
    sz = ({q.ctrl[URPU_CTRL_CSZ2], q.cfg[URPU_CFG_CSZ +: 2]} == URPU_CSZ_NINE) ? 4'h9
         : {2'h0, q.cfg[URPU_CFG_CSZ +: 2]} + 4'h5;
    mask = 9'h1ff >> (4'h9 - sz);
    nbits = sz + {3'h0, q.cfg[URPU_CFG_PM + 1]};
    head = q.fifo[q.rp];

    // ---- axi write: take address and data together ----
    d.awr = s_axi_awvalid & s_axi_wvalid & ~q.awr & ~q.bv;
    d.wr = d.awr;
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (q.awr) begin
      d.bv = 1'b1;
      d.bresp = URPU_RESP_OK;
      case (s_axi_awaddr)
        URPU_OFF_DATA: begin
          // a write while the tx buffer is full is dropped
          if (s_axi_wstrb[0] && q.ctrl[URPU_CTRL_TX_ENABLE_BIT] && !q.tbuf_v) begin
            d.tbuf = {q.ctrl[URPU_CTRL_TX_NINTH_BIT], s_axi_wdata[7:0]};
            d.tbuf_v = 1'b1;
          end
        end
        // error flag positions ignore writes; only speed is writable
        URPU_OFF_STAT: if (s_axi_wstrb[0]) d.u2x = s_axi_wdata[URPU_STAT_U2X];
        URPU_OFF_CTRL: if (s_axi_wstrb[0]) d.ctrl = s_axi_wdata[7:0];
        URPU_OFF_CFG:  if (s_axi_wstrb[0]) d.cfg = s_axi_wdata[7:0];
        URPU_OFF_BAUD: begin
          if (s_axi_wstrb[0]) d.baud[7:0] = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) d.baud[15:8] = s_axi_wdata[15:8];
        end
        default: d.bresp = URPU_RESP_DEC;
      endcase
    end

    // ---- axi read ----
    d.arr = s_axi_arvalid & ~q.arr & ~q.rv;
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
    if (q.arr) begin
      d.rv = 1'b1;
      d.rresp = URPU_RESP_OK;
      d.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        URPU_OFF_DATA: begin
          d.rdata[7:0] = head.d[7:0];
          pop = (q.cnt != 2'h0);
        end
        URPU_OFF_STAT: begin
          d.rdata[URPU_STAT_RXC] = (q.cnt != 2'h0);
          d.rdata[URPU_STAT_TXE] = ~q.tbuf_v & ~q.tbusy;
          d.rdata[URPU_STAT_FE] = head.fe;
          d.rdata[URPU_STAT_DOR] = head.overrun_flag;
          d.rdata[URPU_STAT_PE] = head.pe;
          d.rdata[URPU_STAT_U2X] = q.u2x;
        end
        URPU_OFF_CTRL: begin
          d.rdata[7:0] = q.ctrl;
          d.rdata[URPU_CTRL_RX_NINTH_BIT] = head.d[8];
        end
        URPU_OFF_CFG:  d.rdata[7:0] = q.cfg;
        URPU_OFF_BAUD: d.rdata[15:0] = q.baud;
        default:       d.rresp = URPU_RESP_DEC;
      endcase
    end

    // ---- receiver: sampling and vote ----
    bitv = sync ? q.rs2 : ((q.v[0] & q.v[1]) | (q.v[0] & q.rs2) | (q.v[1] & q.rs2));
    // synchronous mode takes one decision per rising transfer clock edge
    dec = sync ? xck_rise : (tick && q.scnt == mid + 5'h02);
    if (tick) begin
      d.rprev = q.rs2;
    end
    if (tick && q.st != URPU_IDLE) begin
      d.scnt = (q.scnt == spb) ? 5'h01 : q.scnt + 5'h01;
    end
    if (tick && q.scnt == mid) d.v[0] = q.rs2;
    if (tick && q.scnt == mid + 5'h01) d.v[1] = q.rs2;
    case (q.st)
      URPU_IDLE: begin
        // falling edge in async mode, counted as sample one; sync mode starts on a low line at a transfer clock rise
        if (sync ? (xck_rise && !q.rs2) : (tick && q.rprev && !q.rs2)) begin
          start_ok = 1'b1;
          d.st = sync ? URPU_DATA : URPU_START;
          d.scnt = 5'h01;
          d.bidx = 4'h0;
        end
      end
      URPU_START: if (dec) d.st = bitv ? URPU_IDLE : URPU_DATA;
      URPU_DATA: begin
        if (dec) begin
          d.sh[q.bidx] = bitv;
          if (q.bidx == nbits - 4'h1) d.st = URPU_STOP;
          else d.bidx = q.bidx + 4'h1;
        end
      end
      URPU_STOP: begin
        // idle right after the vote, so a second stop is just idle line
        if (dec) begin
          done = 1'b1;
          d.st = URPU_IDLE;
        end
      end
      default: d.st = URPU_IDLE;
    endcase
    if (start_ok && q.cnt == 2'h2 && q.pend_v) begin
      d.ovr = 1'b1;
    end
    // finished frame with its flags
    fr.d = q.sh[8:0] & mask;
    fr.fe = ~bitv;
    fr.overrun_flag = 1'b0;
    fr.pe = q.cfg[URPU_CFG_PM + 1] & (^fr.d ^ q.sh[sz] ^ q.cfg[URPU_CFG_PM]);

    // ---- receive buffer: pop, move waiting char, then new frame ----
    if (pop) begin
      d.cnt = q.cnt - 2'h1;
      d.rp = ~q.rp;
    end
    if (q.pend_v && d.cnt != 2'h2) begin
      push = 1'b1;
      push_ent = q.pend;
      push_ent.overrun_flag = q.ovr;
      d.fifo[d.wp] = push_ent;
      d.wp = ~d.wp;
      d.cnt = d.cnt + 2'h1;
      d.pend_v = 1'b0;
      d.ovr = 1'b0;
    end
    if (done) begin
      if (!d.pend_v && d.cnt != 2'h2) begin
        push = 1'b1;
        push_ent = fr;
        d.fifo[d.wp] = fr;
        d.wp = ~d.wp;
        d.cnt = d.cnt + 2'h1;
      end else begin
        // a char still waiting here is lost to the new one
        d.pend = fr;
        d.pend_v = 1'b1;
      end
    end
    // disabling the receiver is immediate and drops everything
    if (!d.ctrl[URPU_CTRL_RX_ENABLE_BIT]) begin
      d.st = URPU_IDLE;
      d.cnt = 2'h0;
      d.rp = 1'b0;
      d.wp = 1'b0;
      d.pend_v = 1'b0;
      d.ovr = 1'b0;
    end
    d.own = d.ctrl[URPU_CTRL_RX_ENABLE_BIT];
    d.irq = d.ctrl[URPU_CTRL_RXIE] & (d.cnt != 2'h0);

    // ---- transmitter: frame build and shift ----
    tm = q.tbuf & mask;
    tfrm[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < sz) tfrm[i + 1] = tm[i];
    end
    if (q.cfg[URPU_CFG_PM + 1]) begin
      tfrm[sz + 4'h1] = ^tm ^ q.cfg[URPU_CFG_PM];
    end
    tx_bt = sync ? xck_rise : (tick && q.tcnt == spb - 5'h01);
    if (tick) begin
      d.tcnt = (q.tcnt == spb - 5'h01) ? 5'h00 : q.tcnt + 5'h01;
    end
    if (q.tbusy) begin
      if (tx_bt) begin
        d.frm = {1'b1, q.frm[12:1]};
        d.tleft = q.tleft - 4'h1;
        if (q.tleft == 4'h1) d.tbusy = 1'b0;
      end
    end else if (q.tbuf_v) begin
      d.frm = tfrm;
      d.tleft = 4'h2 + nbits + {3'h0, q.cfg[URPU_CFG_SBS]};
      d.tbusy = 1'b1;
      d.tbuf_v = 1'b0;
      d.tcnt = 5'h00;
    end
    d.out = d.tbusy ? d.frm[0] : 1'b1;
    // pin kept until the shifter and buffer are empty
    d.toe = d.ctrl[URPU_CTRL_TX_ENABLE_BIT] | d.tbusy | d.tbuf_v;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
      q.rs1 <= 1'b1;
      q.rs2 <= 1'b1;
      q.rprev <= 1'b1;
      q.ctrl <= URPU_CTRL_RST;
      q.cfg <= URPU_CFG_RST;
      q.baud <= URPU_BAUD_RST;
      q.st <= URPU_IDLE;
      q.out <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign serial_out_pin = q.out;
  assign serial_out_oe  = q.toe;
  assign rx_pin_owned   = q.own;
  assign rx_irq         = q.irq;
  assign s_axi_awready  = q.awr;
  assign s_axi_wready   = q.wr;
  assign s_axi_bvalid   = q.bv;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_arready  = q.arr;
  assign s_axi_rvalid   = q.rv;
  assign s_axi_rresp    = q.rresp;
  assign s_axi_rdata    = q.rdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rx_flush;
    (!q.ctrl[URPU_CTRL_RX_ENABLE_BIT] && !d.ctrl[URPU_CTRL_RX_ENABLE_BIT])
      |=> (q.cnt == 2'h0) && (q.st == URPU_IDLE) && !q.irq;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx disable left data");

  property p_irq_hold;
    // the enables of the coming edge count too: a disable there flushes legally
    (q.ctrl[URPU_CTRL_RXIE] && q.ctrl[URPU_CTRL_RX_ENABLE_BIT] && q.cnt == 2'h2
      && d.ctrl[URPU_CTRL_RXIE] && d.ctrl[URPU_CTRL_RX_ENABLE_BIT]) |=> q.irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped with data");

  property p_tx_hold;
    (q.tbusy && q.tleft > 4'h2 && !tx_bt) |=> serial_out_oe;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx pin released early");

  property p_own;
    $rose(q.ctrl[URPU_CTRL_RX_ENABLE_BIT]) |=> rx_pin_owned;
  endproperty
  a_own: assert property (p_own) else $error("rx pin not taken");

  property p_ovr;
    (start_ok && q.cnt == 2'h2 && q.pend_v && d.ctrl[URPU_CTRL_RX_ENABLE_BIT] && !pop) |=> q.ovr;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");

  property p_ovr_clr;
    (q.pend_v && q.cnt != 2'h2) |=> !q.ovr;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

  property p_pe_off;
    (push && !q.cfg[URPU_CFG_PM + 1] && !q.pend_v) |-> !push_ent.pe;
  endproperty
  a_pe_off: assert property (p_pe_off) else $error("parity error while off");

  property p_mask;
    push |-> ((push_ent.d & ~mask) == 9'h000);
  endproperty
  a_mask: assert property (p_mask) else $error("upper data bits set");

  property p_stop_idle;
    (q.st == URPU_STOP && dec && q.ctrl[URPU_CTRL_RX_ENABLE_BIT]) |=> q.st == URPU_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no idle after stop");

  c_overrun:  cover property (q.ovr);
  c_frame_er: cover property (push && push_ent.fe);
  c_par_er:   cover property (push && push_ent.pe);
endmodule

//--- include/urpu_pkg.sv
// shared constants and types of the serial receiver with parity unit
package urpu_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] URPU_OFF_DATA = 8'h00; // data_buffer_location
  localparam logic [7:0] URPU_OFF_STAT = 8'h04; // status_reg_a
  localparam logic [7:0] URPU_OFF_CTRL = 8'h08; // control_reg_b
  localparam logic [7:0] URPU_OFF_CFG  = 8'h0c; // frame_config_reg_c
  localparam logic [7:0] URPU_OFF_BAUD = 8'h10; // oversample divisor
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int URPU_STAT_RXC  = 7; // rx_complete_flag
  localparam int URPU_STAT_TXE  = 5; // transmitter empty
  localparam int URPU_STAT_FE   = 4; // frame_error_flag
  localparam int URPU_STAT_DOR  = 3; // overrun_flag
  localparam int URPU_STAT_PE   = 2; // parity_error_flag
  localparam int URPU_STAT_U2X  = 1; // double_speed_bit
  localparam int URPU_CTRL_RXIE = 7; // rx_complete_irq_enable
  localparam int URPU_CTRL_RX_ENABLE_BIT = 4; // rx_enable_bit
  localparam int URPU_CTRL_TX_ENABLE_BIT = 3; // tx_enable_bit
  localparam int URPU_CTRL_CSZ2 = 2; // char_size_field bit 2
  localparam int URPU_CTRL_RX_NINTH_BIT = 1; // rx_ninth_bit
  localparam int URPU_CTRL_TX_NINTH_BIT = 0; // tx_ninth_bit
  localparam int URPU_CFG_SYNC  = 6; // synchronous mode
  localparam int URPU_CFG_PM    = 4; // parity_mode_field, 2 bits
  localparam int URPU_CFG_SBS   = 3; // stop_bit_select
  localparam int URPU_CFG_CSZ   = 1; // char_size_field bits 1:0
  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [7:0]  URPU_CTRL_RST = 8'h00;
  localparam logic [7:0]  URPU_CFG_RST  = 8'h06;
  localparam logic [15:0] URPU_BAUD_RST = 16'h000c;
  localparam logic [4:0]  URPU_OSR_NORM = 5'h10; // samples per bit, normal
  localparam logic [4:0]  URPU_OSR_DBL  = 5'h08; // samples per bit, double
  localparam logic [2:0]  URPU_CSZ_NINE = 3'h7;
  localparam logic [1:0]  URPU_RESP_OK  = 2'h0;
  localparam logic [1:0]  URPU_RESP_DEC = 2'h3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    URPU_IDLE  = 4'b0001,
    URPU_START = 4'b0010,
    URPU_DATA  = 4'b0100,
    URPU_STOP  = 4'b1000
  } urpu_rx_st_t;
  typedef struct packed {
    logic       pe;  // parity error of this frame
    logic       overrun_flag; // data lost before this frame
    logic       fe;  // first stop bit sampled low
    logic [8:0] d;   // data, unused upper bits zero
  } urpu_ent_t;
endpackage

//--- sim/urpu_line_model.sv
// remote serial transmitter that drives the receive line of the unit
`timescale 1ns/1ns
module urpu_line_model (
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [15:0] bits,
  input  wire logic [4:0]  nbits,
  input  wire logic [4:0]  bit_len,
  output logic             line,
  output logic             xck,
  output logic             busy
);
  logic [15:0] sh_q;   // bits still to send, lsb first
  logic [4:0]  left_q; // bits left, current one included
  logic [4:0]  cnt_q;  // clocks left in the current bit
  initial begin
    line = 1'h1;
    xck  = 1'h0;
    busy = 1'h0;
  end
  // xck rises once per bit, half a bit after the line changes, and stays
  // low between frames so a synchronous receiver sees no stray edges
  // ----------------------------------------
  // frame shifter
  // ----------------------------------------
  // one bit per bit_len clocks; line idles high between frames as a real
  // transmitter leaves it, so a new frame always starts with a falling edge
  always @(posedge core_clk) begin
    if (go && !busy) begin
      sh_q   <= bits;
      left_q <= nbits;
      cnt_q  <= bit_len - 5'h01;
      busy   <= 1'h1;
      line   <= bits[0];
      xck    <= 1'h0;
    end else if (busy) begin
      if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
        xck   <= (cnt_q <= {1'h0, bit_len[4:1]});
      end else if (left_q == 5'h01) begin
        busy <= 1'h0;
        line <= 1'h1;
        xck  <= 1'h0;
      end else begin
        xck    <= 1'h0;
        sh_q   <= sh_q >> 1;
        line   <= sh_q[1];
        left_q <= left_q - 5'h01;
        cnt_q  <= bit_len - 5'h01;
      end
    end
  end
endmodule

//--- sim/tb_top.sv
// self-checking bench of the serial receiver with parity unit
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top
  import urpu_pkg::*;
;
  logic        core_clk, rst, serial_in_pin, transfer_clock_pin, serial_out_pin;
  logic        serial_out_oe, rx_pin_owned, rx_irq, go, busy;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] bits;
  logic [4:0]  nbits, bit_len;
  logic [10:0] tx;        // captured transmit frame
  int          fail_count, num_checks, k;
  // one row: config, {c2,u2x,bad parity,stop}, data sent, data expected, {fe,pe}
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] f;
    logic [8:0] d;
    logic [8:0] x;
    logic [1:0] e;
  } urpu_row_t;
  urpu_row_t   rows [9];
  urpu_row_t   w;
  urpu_top u_urpu_top (.core_clk, .rst, .serial_in_pin, .transfer_clock_pin, .serial_out_pin,
    .serial_out_oe, .rx_pin_owned, .rx_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  urpu_line_model u_urpu_line_model (.core_clk, .go, .bits, .nbits, .bit_len,
    .line(serial_in_pin), .xck(transfer_clock_pin), .busy);
  // ----------------------------------------
  // clock, watchdog, verdict
  // ----------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // the whole run needs well under 10000 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    finish_test();
  end
  // ----------------------------------------
  // bus tasks: each starts one edge later so no signal is set twice at once
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
    `CHK(s_axi_bvalid, 1'h1, "no write response")
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    int n;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    rr = s_axi_rresp;
    `CHK(s_axi_rvalid, 1'h1, "no read response")
  endtask
  // ----------------------------------------
  // line and entry tasks
  // ----------------------------------------
  // builds start, data lsb first, optional parity, first stop; waits for the end
  task automatic send(input logic [7:0] cfg, input logic [3:0] f, input logic [8:0] d);
    int nd;
    int i;
    logic [15:0] v;
    nd = f[3] ? 9 : 5 + int'(cfg[2:1]);
    v = '1;
    v[0] = 1'h0;
    for (i = 0; i < nd; i++) v[1+i] = d[i];
    i = nd + 1;
    if (cfg[5]) begin
      v[i] = ^(d & 9'((1 << nd) - 1)) ^ cfg[4] ^ f[1];
      i++;
    end
    v[i] = f[0];
    @(posedge core_clk);
    bits    <= v;
    nbits   <= 5'(i + 1);
    bit_len <= f[2] ? 5'h08 : 5'h10;
    go      <= 1'h1;
    @(posedge core_clk);
    go <= 1'h0;
    @(posedge core_clk);
    for (i = 0; i < 400 && busy; i++) @(posedge core_clk);
  endtask
  task automatic waitrx();
    for (int n = 0; n < 60; n++) begin
      rd(URPU_OFF_STAT, q, r);
      if (q[URPU_STAT_RXC] === 1'h1) break;
    end
  endtask
  // status and ninth bit first, then the data that pops the entry
  task automatic rdent(input logic [8:0] x, input logic [1:0] e, input logic ov);
    rd(URPU_OFF_STAT, q, r);
    `CHK({q[URPU_STAT_FE], q[URPU_STAT_PE]}, e, "error flags")
    `CHK(q[URPU_STAT_DOR], ov, "overrun flag")
    rd(URPU_OFF_CTRL, q, r);
    `CHK(q[URPU_CTRL_RX_NINTH_BIT], x[8], "ninth bit")
    rd(URPU_OFF_DATA, q, r);
    `CHK(q[7:0], x[7:0], "received data")
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rows[0] = '{8'h06, 4'h1, 9'h0a5, 9'h0a5, 2'h0};
    rows[1] = '{8'h00, 4'h1, 9'h1ff, 9'h01f, 2'h0};
    rows[2] = '{8'h22, 4'h1, 9'h02d, 9'h02d, 2'h0};
    rows[3] = '{8'h34, 4'h3, 9'h055, 9'h055, 2'h1};
    rows[4] = '{8'h0e, 4'h0, 9'h03c, 9'h03c, 2'h2};
    rows[5] = '{8'h06, 4'h9, 9'h1a3, 9'h1a3, 2'h0};
    rows[6] = '{8'h26, 4'h5, 9'h081, 9'h081, 2'h0};
    rows[7] = '{8'h16, 4'h3, 9'h07e, 9'h07e, 2'h0};
    rows[8] = '{8'h46, 4'h1, 9'h0c3, 9'h0c3, 2'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {go, bits, nbits, bit_len} = 27'h0;
    rst = 1'h1;
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    rd(URPU_OFF_CTRL, q, r);
    `CHK(q[7:0], URPU_CTRL_RST, "ctrl reset value")
    rd(URPU_OFF_CFG, q, r);
    `CHK(q[7:0], URPU_CFG_RST, "config reset value")
    rd(URPU_OFF_BAUD, q, r);
    `CHK(q[15:0], URPU_BAUD_RST, "divisor reset value")
    rd(8'h20, q, r);
    `CHK({r, q}, {URPU_RESP_DEC, 32'h0}, "unmapped read")
    wr(URPU_OFF_BAUD, 8'h00);
    `CHK(r, URPU_RESP_OK, "write response")
    wr(8'h24, 8'hff);
    `CHK(r, URPU_RESP_DEC, "unmapped write")
    $display("test reset done");
    // one frame per row, irq enabled; error bits always written as zero
    for (k = 0; k < 9; k++) begin
      w = rows[k];
      wr(URPU_OFF_CFG, w.cfg);
      wr(URPU_OFF_STAT, {6'h00, w.f[2], 1'h0});
      wr(URPU_OFF_CTRL, {4'h9, 1'h0, w.f[3], 2'h0});
      send(w.cfg, w.f, w.d);
      `CHK(rx_pin_owned, 1'h1, "pin not given to receiver")
      waitrx();
      wr(URPU_OFF_STAT, {6'h00, w.f[2], 1'h0});
      `CHK(rx_irq, 1'h1, "request missing")
      rdent(w.x, w.e, 1'h0);
      rd(URPU_OFF_STAT, q, r);
      `CHK(q[URPU_STAT_RXC], 1'h0, "buffer not empty")
      `CHK(rx_irq, 1'h0, "request stuck")
      $display("test row %0d done", k);
    end
    // four frames unread: the fourth replaces the one waiting in the shifter
    wr(URPU_OFF_CFG, 8'h06);
    wr(URPU_OFF_STAT, 8'h00);
    wr(URPU_OFF_CTRL, 8'h10);
    for (k = 1; k < 5; k++) send(8'h06, 4'h1, 9'(8'h11 * k));
    waitrx();
    rdent(9'h011, 2'h0, 1'h0);
    rdent(9'h022, 2'h0, 1'h0);
    rdent(9'h044, 2'h0, 1'h1);
    rd(URPU_OFF_STAT, q, r);
    `CHK(q[URPU_STAT_RXC], 1'h0, "lost frame kept")
    send(8'h06, 4'h1, 9'h055);
    waitrx();
    rdent(9'h055, 2'h0, 1'h0);
    $display("test overrun done");
    // disable with an unread entry: flushed at once, pin handed back
    wr(URPU_OFF_CTRL, 8'h90);
    send(8'h06, 4'h1, 9'h0f0);
    waitrx();
    wr(URPU_OFF_CTRL, 8'h80);
    repeat (2) @(posedge core_clk);
    `CHK({rx_pin_owned, rx_irq}, 2'h0, "disable not immediate")
    wr(URPU_OFF_CTRL, 8'h90);
    rd(URPU_OFF_STAT, q, r);
    `CHK(q[URPU_STAT_RXC], 1'h0, "flushed data kept")
    $display("test flush done");
    // a four-clock low spike: centre samples high, so no frame may follow
    @(posedge core_clk);
    {bits, nbits, bit_len, go} <= {16'hfffe, 5'h01, 5'h04, 1'h1};
    @(posedge core_clk);
    go <= 1'h0;
    repeat (250) @(posedge core_clk);
    rd(URPU_OFF_STAT, q, r);
    `CHK(q[URPU_STAT_RXC], 1'h0, "noise spike taken as start")
    $display("test noise done");
    // odd parity on transmit, disable while the frame is pending
    wr(URPU_OFF_CFG, 8'h36);
    wr(URPU_OFF_CTRL, 8'h08);
    wr(URPU_OFF_DATA, 8'h5a);
    wr(URPU_OFF_CTRL, 8'h00);
    for (k = 0; k < 400 && serial_out_pin !== 1'h0; k++) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    for (k = 0; k < 11; k++) begin
      tx[k] = serial_out_pin;
      `CHK(serial_out_oe, 1'h1, "pin released early")
      repeat (16) @(posedge core_clk);
    end
    `CHK(tx, {2'h3, 8'h5a, 1'h0}, "transmit frame")
    repeat (24) @(posedge core_clk);
    `CHK(serial_out_oe, 1'h0, "pin never released")
    $display("test transmit done");
    finish_test();
  end
endmodule
